/* shared/nipc_pkg.sv */
// constants and types of the nested interrupt priority controller
package nipc_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_EXT_EN_A = 8'h08;
   localparam logic [7:0] IDX_PRIO0 = 8'h32;
   localparam logic [7:0] IDX_PRIO1 = 8'h33;
   localparam logic [7:0] IDX_PRIO2 = 8'h34;
   localparam logic [7:0] IDX_PRIO3 = 8'h35;
   localparam logic [7:0] IDX_EXT_EN_B = 8'h39;
   localparam logic [7:0] IDX_COND = 8'h3a;
   localparam logic [7:0] IDX_MISC = 8'h3b;
   localparam logic [7:0] IDX_PEND = 8'h3c;
   localparam logic [7:0] IDX_NONE = 8'hff;
   // reset values and fixed bits
   localparam logic [7:0] RST_EXT_EN = 8'h00;
   localparam logic [7:0] RST_PRIO = 8'hff;
   localparam logic [7:0] PRIO3_RO = 8'hf0;
   localparam logic [7:0] CC_FIXED = 8'hc0;
   localparam logic [1:0] RST_SMS = 2'h0;
   localparam logic [12:0] RST_PINS = 13'h1fff;
   // field positions
   localparam int CC_BIT_HI = 5;
   localparam int CC_BIT_LO = 3;
   localparam int SENSE_LO_POS = 4;
   localparam int SENSE_HI_POS = 6;
   // priority codes {high, low}
   localparam logic [1:0] CODE_L0 = 2'h2;
   localparam logic [1:0] CODE_L1 = 2'h1;
   localparam logic [1:0] CODE_L2 = 2'h0;
   localparam logic [1:0] CODE_L3 = 2'h3;
   // shared pin sensitivity codes
   localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
   localparam logic [1:0] SENSE_RISE = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_BOTH = 2'h3;
   // cpu operations
   localparam logic [2:0] OP_UNMASK = 3'h0;
   localparam logic [2:0] OP_MASK = 3'h1;
   localparam logic [2:0] OP_HALT = 3'h2;
   localparam logic [2:0] OP_WAIT = 3'h3;
   localparam logic [2:0] OP_RETURN = 3'h4;
   localparam logic [2:0] OP_POP = 3'h5;
   // vectors
   localparam int NUM_VEC = 14;
   localparam logic [3:0] ID_TOP = 4'h0;
   localparam logic [3:0] ID_TRAP = 4'hf;
   localparam logic [15:0] VEC_TOP = 16'hfffa;
   localparam logic [15:0] VEC_TRAP = 16'hfffc;
   localparam logic [13:0] HALT_WAKE = 14'h005f;
   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_WAIT = 2'b01,
      MODE_HALT = 2'b10
   } nipc_mode_type;
endpackage

/* verilog/nipc_top.sv */
// nested interrupt priority controller with register slave
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module nipc_top
   import nipc_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // register bus
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // cpu core
   input wire logic CPU_OP_STB,
   input wire logic [2:0] CPU_OP,
   input wire logic [7:0] CPU_CC_IN,
   input wire logic CPU_TRAP,
   input wire logic CPU_IRQ_ACK,
   output logic IRQ_REQ,
   output logic [15:0] IRQ_VEC,
   output logic [7:0] CPU_CC_OUT,
   output logic CPU_CLK_EN,
   output logic PERIPH_CLK_EN,
   output logic WAIT_MODE,
   output logic HALT_MODE,
   // pins and peripheral requests
   input wire logic [11:0] EXT_PIN_IRQ_N,
   input wire logic TOP_LEVEL_PIN_IRQ,
   input wire logic NMI_REQ,
   input wire logic USB_SUSP_REQ,
   input wire logic [5:0] PERIPH_REQ
);
   function automatic logic [1:0] lvl(input logic [1:0] code);
      case (code)
         CODE_L0: lvl = 2'd0;
         CODE_L1: lvl = 2'd1;
         CODE_L2: lvl = 2'd2;
         default: lvl = 2'd3;
      endcase
   endfunction

   function automatic logic [7:0] prio_wr(input logic [7:0] old,
                                          input logic [7:0] nw);
      logic [7:0] r;
      r = nw;
      for (int i = 0; i < 4; i++) begin
         if (nw[2*i +: 2] == CODE_L0) begin
            r[2*i +: 2] = old[2*i +: 2];
         end
      end
      prio_wr = r;
   endfunction

   // any enabled low input drives the line high
   function automatic logic nand_line(input logic [3:0] v,
                                      input logic [3:0] en);
      nand_line = ~&(v | ~en);
   endfunction

   function automatic logic sense_ev(input logic [1:0] sel,
                                     input logic rise,
                                     input logic fall);
      case (sel)
         SENSE_RISE: sense_ev = fall;
         SENSE_BOTH: sense_ev = rise | fall;
         default: sense_ev = rise;
      endcase
   endfunction

   // group lines, high while an enabled pin of the group requests
   function automatic logic [5:0] group_lines(input logic [12:0] p,
                                              input logic [7:0] ea,
                                              input logic [7:0] eb);
      logic [5:0] g;
      g[0] = nand_line(p[3:0], ea[3:0]);
      g[1] = nand_line({2'b11, p[7:6]}, {2'b00, ea[7:6]});
      g[2] = nand_line({2'b11, ~p[5:4]}, {2'b00, ea[5:4]});
      g[3] = nand_line({2'b11, p[9:8]}, {2'b00, eb[1:0]});
      g[4] = nand_line({2'b11, p[11:10]}, {2'b00, eb[3:2]});
      g[5] = p[12];
      group_lines = g;
   endfunction

   // registers
   logic [7:0] en_a_q, en_b_q;
   logic [7:0] p0_q, p1_q, p2_q, p3_q;
   logic [1:0] cur_q, sms_q;
   nipc_mode_type mode_q, mode_d;
   logic trap_q, tli_q;
   logic [2:0] ext_q;
   logic [12:0] s1_q, s2_q, s3_q, filt_q;
   logic [12:0] filt_p_q;
   logic [2:0] div_q;
   logic irq_q, cpu_en_q, per_en_q;
   logic [3:0] vid_q;
   logic wr_q;
   logic [7:0] widx_q, ridx_q;

   // bus slave, zero wait states
   logic take, mapped;
   logic [7:0] aidx;
   assign take = HSEL & HTRANS[1] & HREADY;
   assign mapped = HADDR[31:10] == 22'h0;
   assign aidx = mapped ? HADDR[9:2] : IDX_NONE;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   logic wr_ena, wr_enb, wr_p0, wr_p1, wr_p2, wr_p3, wr_cc, wr_misc;
   assign wr_ena = wr_q && widx_q == IDX_EXT_EN_A;
   assign wr_enb = wr_q && widx_q == IDX_EXT_EN_B;
   assign wr_p0 = wr_q && widx_q == IDX_PRIO0;
   assign wr_p1 = wr_q && widx_q == IDX_PRIO1;
   assign wr_p2 = wr_q && widx_q == IDX_PRIO2;
   assign wr_p3 = wr_q && widx_q == IDX_PRIO3;
   assign wr_cc = wr_q && widx_q == IDX_COND;
   assign wr_misc = wr_q && widx_q == IDX_MISC;

   logic [7:0] wd;
   assign wd = HWDATA[7:0];

   logic [7:0] cc_val;
   assign cc_val = CC_FIXED | (8'(cur_q[1]) << CC_BIT_HI)
                 | (8'(cur_q[0]) << CC_BIT_LO);

   // pin conditioning
   logic [12:0] pins, agree, filt_d;
   assign pins = {TOP_LEVEL_PIN_IRQ, EXT_PIN_IRQ_N};
   assign agree = ~(s2_q ^ s3_q);
   assign filt_d = (agree & s2_q) | (~agree & filt_q);

   logic [5:0] lines, lines_p, rise, fall;
   assign lines = group_lines(filt_q, en_a_q, en_b_q);
   // old pins under the current enables, so an enable write makes no edge
   assign lines_p = group_lines(filt_p_q, en_a_q, en_b_q);
   assign rise = lines & ~lines_p;
   assign fall = ~lines & lines_p;

   logic [1:0] sense_lo, sense_hi;
   assign sense_lo = en_b_q[SENSE_LO_POS +: 2];
   assign sense_hi = en_b_q[SENSE_HI_POS +: 2];

   logic [2:0] ext_ev;
   logic lvl_c;
   assign ext_ev[0] = rise[0];
   assign ext_ev[1] = rise[1] | rise[2];
   assign ext_ev[2] = sense_ev(sense_lo, rise[3], fall[3])
                    | sense_ev(sense_hi, rise[4], fall[4]);
   assign lvl_c = (sense_lo == SENSE_FALL_LOW && lines[3])
                | (sense_hi == SENSE_FALL_LOW && lines[4]);

   // request vector in hardware order, index 0 highest
   logic [13:0] req, cand;
   assign req = {3'b000, PERIPH_REQ,
                 ext_q[2] | lvl_c, ext_q[1:0],
                 USB_SUSP_REQ, tli_q | NMI_REQ};
   assign cand = req & ((mode_q == MODE_HALT) ? HALT_WAKE
                                             : 14'h3fff);

   logic [27:0] prio_all;
   assign prio_all = {p3_q[3:0], p2_q, p1_q, p0_q};

   // arbitration
   logic found;
   logic [3:0] sel_id;
   logic [1:0] sel_lvl;
   logic [1:0] k_lvl;
   always_comb begin
      found = 1'b0;
      sel_id = ID_TOP;
      sel_lvl = 2'd0;
      k_lvl = 2'd0;
      if (trap_q && mode_q == MODE_RUN) begin
         found = 1'b1;
         sel_id = ID_TRAP;
      end else if (cand[0]) begin
         found = 1'b1;
         sel_id = ID_TOP;
      end else begin
         for (int k = NUM_VEC - 1; k >= 1; k--) begin
            k_lvl = lvl(prio_all[2*k +: 2]);
            if (cand[k] && k_lvl > lvl(cur_q)
                && (!found || k_lvl >= sel_lvl)) begin
               found = 1'b1;
               sel_id = 4'(k);
               sel_lvl = k_lvl;
            end
         end
      end
   end

   logic ack;
   logic [1:0] ack_code;
   assign ack = CPU_IRQ_ACK & irq_q;
   assign ack_code = (vid_q == ID_TRAP || vid_q == ID_TOP) ? CODE_L3
                   : prio_all[{vid_q, 1'b0} +: 2];

   logic [1:0] op_code;
   assign op_code = (CPU_OP == OP_MASK) ? CODE_L3
                  : (CPU_OP == OP_RETURN || CPU_OP == OP_POP)
                    ? {CPU_CC_IN[CC_BIT_HI], CPU_CC_IN[CC_BIT_LO]}
                  : (CPU_OP <= OP_WAIT) ? CODE_L0
                  : cur_q;

   logic [1:0] cur_d;
   assign cur_d = ack ? ack_code
                : CPU_OP_STB ? op_code
                : wr_cc ? {wd[CC_BIT_HI], wd[CC_BIT_LO]}
                : cur_q;

   always_comb begin
      mode_d = mode_q;
      if (ack || (irq_q && mode_q != MODE_RUN)) begin
         mode_d = MODE_RUN;
      end else if (CPU_OP_STB && CPU_OP == OP_HALT) begin
         mode_d = MODE_HALT;
      end else if (CPU_OP_STB && CPU_OP == OP_WAIT) begin
         mode_d = MODE_WAIT;
      end
   end

   // latches, set wins over clear
   logic [2:0] ext_clr;
   logic tli_clr, trap_clr;
   assign ext_clr[0] = ack && vid_q == 4'h2;
   assign ext_clr[1] = ack && vid_q == 4'h3;
   assign ext_clr[2] = ack && vid_q == 4'h4;
   assign tli_clr = ack && vid_q == ID_TOP;
   assign trap_clr = ack && vid_q == ID_TRAP;

   logic [2:0] ext_d;
   logic tli_d, trap_d;
   assign ext_d = ext_ev | (ext_q & ~ext_clr);
   assign tli_d = rise[5] | (tli_q & ~tli_clr);
   assign trap_d = CPU_TRAP | (trap_q & ~trap_clr);

   // clock enables
   logic [2:0] div_lim, div_d;
   logic tick;
   assign div_lim = 3'((4'd1 << sms_q) - 4'd1);
   assign tick = div_q >= div_lim;
   assign div_d = tick ? 3'd0 : 3'(div_q + 3'd1);

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         wr_q <= 1'b0;
         widx_q <= IDX_NONE;
         ridx_q <= IDX_NONE;
      end else begin
         wr_q <= take & HWRITE;
         widx_q <= take ? aidx : IDX_NONE;
         ridx_q <= (take & ~HWRITE) ? aidx : IDX_NONE;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         en_a_q <= RST_EXT_EN;
         en_b_q <= RST_EXT_EN;
         p0_q <= RST_PRIO;
         p1_q <= RST_PRIO;
         p2_q <= RST_PRIO;
         p3_q <= RST_PRIO;
         sms_q <= RST_SMS;
      end else begin
         if (wr_ena) begin
            en_a_q <= wd;
         end
         if (wr_enb) begin
            en_b_q <= wd;
         end
         if (wr_p0) begin
            p0_q <= prio_wr(p0_q, wd);
         end
         if (wr_p1) begin
            p1_q <= prio_wr(p1_q, wd);
         end
         if (wr_p2) begin
            p2_q <= prio_wr(p2_q, wd);
         end
         if (wr_p3) begin
            p3_q <= prio_wr(p3_q, wd) | PRIO3_RO;
         end
         if (wr_misc) begin
            sms_q <= wd[1:0];
         end
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cur_q <= CODE_L3;
         mode_q <= MODE_RUN;
         trap_q <= 1'b0;
         tli_q <= 1'b0;
         ext_q <= 3'h0;
         irq_q <= 1'b0;
         vid_q <= ID_TOP;
      end else begin
         cur_q <= cur_d;
         mode_q <= mode_d;
         trap_q <= trap_d;
         tli_q <= tli_d;
         ext_q <= ext_d;
         irq_q <= found & ~ack;
         vid_q <= sel_id;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         s1_q <= RST_PINS;
         s2_q <= RST_PINS;
         s3_q <= RST_PINS;
         filt_q <= RST_PINS;
         filt_p_q <= RST_PINS;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
         filt_p_q <= filt_q;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         div_q <= 3'd0;
         cpu_en_q <= 1'b0;
         per_en_q <= 1'b0;
      end else begin
         div_q <= div_d;
         cpu_en_q <= tick && mode_q == MODE_RUN;
         per_en_q <= tick && mode_q != MODE_HALT;
      end
   end

   // read data from the registered index of the data phase
   logic [31:0] rd_word;
   assign rd_word = (ridx_q == IDX_EXT_EN_A) ? {24'h0, en_a_q}
                  : (ridx_q == IDX_EXT_EN_B) ? {24'h0, en_b_q}
                  : (ridx_q == IDX_PRIO0) ? {24'h0, p0_q}
                  : (ridx_q == IDX_PRIO1) ? {24'h0, p1_q}
                  : (ridx_q == IDX_PRIO2) ? {24'h0, p2_q}
                  : (ridx_q == IDX_PRIO3) ? {24'h0, p3_q}
                  : (ridx_q == IDX_COND) ? {24'h0, cc_val}
                  : (ridx_q == IDX_MISC) ? {30'h0, sms_q}
                  : (ridx_q == IDX_PEND) ? {16'h0, trap_q, 1'b0, req}
                  : 32'h0;
   assign HRDATA = rd_word;

   assign IRQ_REQ = irq_q;
   assign IRQ_VEC = (vid_q == ID_TRAP) ? VEC_TRAP
                  : 16'(VEC_TOP - {11'h0, vid_q, 1'b0});
   assign CPU_CC_OUT = cc_val;
   assign CPU_CLK_EN = cpu_en_q;
   assign PERIPH_CLK_EN = per_en_q;
   assign WAIT_MODE = mode_q == MODE_WAIT;
   assign HALT_MODE = mode_q == MODE_HALT;
endmodule

/* testbench/nipc_checker.sv */
// assertions on the controller ports
`timescale 1ns/1ps
module nipc_checker
   import nipc_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // cpu side
   input wire logic CPU_OP_STB,
   input wire logic [2:0] CPU_OP,
   input wire logic [7:0] CPU_CC_IN,
   input wire logic CPU_TRAP,
   input wire logic CPU_IRQ_ACK,
   input wire logic IRQ_REQ,
   input wire logic [15:0] IRQ_VEC,
   input wire logic [7:0] CPU_CC_OUT,
   input wire logic CPU_CLK_EN,
   input wire logic WAIT_MODE,
   input wire logic HALT_MODE
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   wire [1:0] lvl = {CPU_CC_OUT[CC_BIT_HI], CPU_CC_OUT[CC_BIT_LO]};
   wire op_ok = CPU_OP_STB && !CPU_IRQ_ACK;
   a_cc_frame: assert property ({CPU_CC_OUT[7:6], CPU_CC_OUT[4], CPU_CC_OUT[2:0]} == 6'h30)
      else $error("cc fixed bits wrong");
   a_mask_op: assert property (op_ok && CPU_OP == OP_MASK |=> lvl == CODE_L3)
      else $error("mask op level wrong");
   a_unmask_op: assert property (op_ok && CPU_OP == OP_UNMASK |=> lvl == CODE_L0)
      else $error("unmask op level wrong");
   a_return_op: assert property (op_ok && CPU_OP == OP_RETURN
      |=> lvl == {$past(CPU_CC_IN[5]), $past(CPU_CC_IN[3])}) else $error("return level wrong");
   a_wait_entry: assert property (op_ok && CPU_OP == OP_WAIT && !IRQ_REQ
      |=> WAIT_MODE && lvl == CODE_L0) else $error("wait entry wrong");
   a_wait_cpu_off: assert property (WAIT_MODE && $past(WAIT_MODE) |-> !CPU_CLK_EN)
      else $error("cpu clocked in wait");
   a_wait_wake: assert property (WAIT_MODE && IRQ_REQ |=> !WAIT_MODE)
      else $error("no wake from wait");
   a_ack_clear: assert property (IRQ_REQ && CPU_IRQ_ACK |=> !IRQ_REQ)
      else $error("request kept after ack");
   a_trap_taken: assert property (CPU_TRAP && !IRQ_REQ && !WAIT_MODE && !HALT_MODE
      |-> ##[1:3] IRQ_REQ && IRQ_VEC == VEC_TRAP) else $error("trap not taken");
   a_nonmask_lvl: assert property (IRQ_REQ && CPU_IRQ_ACK
      && (IRQ_VEC == VEC_TRAP || IRQ_VEC == VEC_TOP) |=> lvl == CODE_L3)
      else $error("non maskable entry level wrong");
endmodule
bind nipc_top nipc_checker nipc_checker_i (
   .MCLK(MCLK), .RST(RST), .CPU_OP_STB(CPU_OP_STB), .CPU_OP(CPU_OP),
   .CPU_CC_IN(CPU_CC_IN), .CPU_TRAP(CPU_TRAP), .CPU_IRQ_ACK(CPU_IRQ_ACK),
   .IRQ_REQ(IRQ_REQ), .IRQ_VEC(IRQ_VEC), .CPU_CC_OUT(CPU_CC_OUT),
   .CPU_CLK_EN(CPU_CLK_EN), .WAIT_MODE(WAIT_MODE), .HALT_MODE(HALT_MODE)
);

/* testbench/nipc_cpu_model.sv */
// cpu model acknowledging interrupt requests
`timescale 1ns/1ps
module nipc_cpu_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // handshake
   input wire logic irq_req,
   input wire logic [3:0] ack_dly,
   output logic irq_ack
);
   logic [3:0] wait_q;
   // one ack pulse after the programmed delay
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wait_q <= 4'h0;
         irq_ack <= 1'b0;
      end else if (irq_req && !irq_ack) begin
         wait_q <= wait_q + 4'h1;
         irq_ack <= (wait_q >= ack_dly);
      end else begin
         wait_q <= 4'h0;
         irq_ack <= 1'b0;
      end
   end
endmodule

/* testbench/nipc_top_bench.sv */
// self-checking bench of the interrupt priority controller
`timescale 1ns/1ps
module nipc_top_bench
   import nipc_pkg::*;
;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic HWRITE = 1'b0;
   logic CPU_OP_STB = 1'b0;
   logic CPU_TRAP = 1'b0;
   logic TOP_LEVEL_PIN_IRQ = 1'b0;
   logic HREADYOUT, HRESP, CPU_IRQ_ACK, IRQ_REQ, s;
   logic CPU_CLK_EN, PERIPH_CLK_EN, WAIT_MODE, HALT_MODE;
   logic [1:0] HTRANS = 2'h0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
   logic [2:0] CPU_OP = 3'h0;
   logic [7:0] CPU_CC_IN = 8'h0, CPU_CC_OUT;
   logic [15:0] IRQ_VEC;
   logic [11:0] EXT_PIN_IRQ_N = 12'hfff;
   logic [5:0] PERIPH_REQ = 6'h0;
   logic [3:0] dly = 4'h0;
   int n_fail = 0;
   int n_tests = 0;
   always #20 MCLK = ~MCLK;
   nipc_top nipc_top_i (
      .MCLK(MCLK), .RST(RST), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .CPU_OP_STB(CPU_OP_STB),
      .CPU_OP(CPU_OP), .CPU_CC_IN(CPU_CC_IN), .CPU_TRAP(CPU_TRAP),
      .CPU_IRQ_ACK(CPU_IRQ_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_VEC(IRQ_VEC),
      .CPU_CC_OUT(CPU_CC_OUT), .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
      .WAIT_MODE(WAIT_MODE), .HALT_MODE(HALT_MODE), .EXT_PIN_IRQ_N(EXT_PIN_IRQ_N),
      .TOP_LEVEL_PIN_IRQ(TOP_LEVEL_PIN_IRQ), .NMI_REQ(1'b0), .USB_SUSP_REQ(1'b0),
      .PERIPH_REQ(PERIPH_REQ)
   );
   nipc_cpu_model nipc_cpu_model_i (
      .mclk(MCLK), .rst(RST), .irq_req(IRQ_REQ), .ack_dly(dly), .irq_ack(CPU_IRQ_ACK)
   );
   task automatic conclude;
      if (n_fail == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask
   task automatic ccis(input logic [7:0] e);
      chk({8'h0, CPU_CC_OUT}, {8'h0, e});
   endtask
   // one edge, stretched while the slave holds ready low
   task automatic edge1;
      int k;
      k = 0;
      @(posedge MCLK);
      while (HREADYOUT !== 1'b1) begin
         k++;
         if (k > 50) begin
            n_fail++;
            conclude;
         end
         @(posedge MCLK);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] r);
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= {22'h0, a, 2'h0};
      edge1;
      HTRANS <= 2'h0;
      HWDATA <= {24'h0, d};
      edge1;
      r = HRDATA;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      bus(1'b0, a, 8'h0, r);
      chk(r[15:0], {8'h0, e});
   endtask
   task automatic op(input logic [2:0] o);
      CPU_OP_STB <= 1'b1;
      CPU_OP <= o;
      @(posedge MCLK);
      CPU_OP_STB <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic wlev(input logic v);
      int k;
      k = 0;
      while (IRQ_REQ !== v) begin
         k++;
         if (k > 40) begin
            n_fail++;
            conclude;
         end
         @(posedge MCLK);
      end
   endtask
   // request seen, then acknowledged entry level
   task automatic serve(input logic [15:0] v, input logic [7:0] cc);
      wlev(1'b1);
      chk(IRQ_VEC, v);
      wlev(1'b0);
      ccis(cc);
   endtask
   task automatic seen;
      s = 1'b0;
      repeat (12) begin
         @(posedge MCLK);
         s = s | IRQ_REQ;
      end
   endtask
   initial begin
      int c;
      repeat (6) @(posedge MCLK);
      RST <= 1'b0;
      ccis(8'he8);
      rd(IDX_EXT_EN_A, RST_EXT_EN);
      for (c = 0; c < 4; c++)
         rd(IDX_PRIO0 + c[7:0], RST_PRIO);
      rd(IDX_EXT_EN_B, RST_EXT_EN);
      rd(8'h3f, 8'h00);
      wr(IDX_PRIO3, 8'h00);
      rd(IDX_PRIO3, PRIO3_RO);
      wr(IDX_PRIO1, 8'hcf);
      wr(IDX_PRIO1, 8'h64);
      rd(IDX_PRIO1, 8'h44);
      wr(IDX_PRIO0, 8'hdf);
      wr(IDX_EXT_EN_A, 8'h11);
      op(OP_UNMASK);
      ccis(8'he0);
      EXT_PIN_IRQ_N[0] <= 1'b0;
      serve(16'hfff6, 8'hc8);
      EXT_PIN_IRQ_N[0] <= 1'b1;
      EXT_PIN_IRQ_N[4] <= 1'b0;
      seen;
      chk({15'h0, s}, 16'h0);
      EXT_PIN_IRQ_N[4] <= 1'b1;
      serve(16'hfff4, 8'he8);
      CPU_TRAP <= 1'b1;
      @(posedge MCLK);
      CPU_TRAP <= 1'b0;
      serve(VEC_TRAP, 8'he8);
      TOP_LEVEL_PIN_IRQ <= 1'b1;
      serve(VEC_TOP, 8'he8);
      TOP_LEVEL_PIN_IRQ <= 1'b0;
      CPU_CC_IN <= 8'h08;
      op(OP_RETURN);
      ccis(8'hc8);
      dly <= 4'h3;
      op(OP_MASK);
      PERIPH_REQ <= 6'h3;
      seen;
      chk({15'h0, s}, 16'h0);
      op(OP_UNMASK);
      serve(16'hffee, 8'hc0);
      PERIPH_REQ <= 6'h1;
      seen;
      chk({15'h0, s}, 16'h0);
      op(OP_UNMASK);
      serve(16'hfff0, 8'hc8);
      wr(IDX_PRIO1, 8'h40);
      serve(16'hfff0, 8'hc0);
      PERIPH_REQ <= 6'h0;
      op(OP_WAIT);
      @(posedge MCLK);
      chk({5'h0, WAIT_MODE, CPU_CLK_EN, PERIPH_CLK_EN, CPU_CC_OUT}, 16'h05e0);
      PERIPH_REQ <= 6'h1;
      serve(16'hfff0, 8'hc0);
      chk({15'h0, WAIT_MODE}, 16'h0);
      PERIPH_REQ <= 6'h0;
      op(OP_HALT);
      @(posedge MCLK);
      chk({5'h0, HALT_MODE, CPU_CLK_EN, PERIPH_CLK_EN, CPU_CC_OUT}, 16'h04e0);
      PERIPH_REQ <= 6'h1;
      seen;
      chk({15'h0, s}, 16'h0);
      PERIPH_REQ <= 6'h2;
      serve(16'hffee, 8'hc0);
      chk({15'h0, HALT_MODE}, 16'h0);
      PERIPH_REQ <= 6'h0;
      for (c = 0; c < 4; c++) begin
         wr(IDX_EXT_EN_B, {2'h0, c[1:0], 4'h1});
         op(OP_UNMASK);
         EXT_PIN_IRQ_N[8] <= 1'b0;
         seen;
         chk({15'h0, s}, {15'h0, c != 1});
         op(OP_MASK);
         EXT_PIN_IRQ_N[8] <= 1'b1;
         repeat (8) @(posedge MCLK);
         op(OP_UNMASK);
         seen;
         chk({15'h0, s}, {15'h0, c[0]});
      end
      conclude;
   end
endmodule
